/* File: design/pin_mux_cfg_regs.sv */
// Purpose: classic wishbone slave holding the configuration registers
// Assumes: single classic cycles, one answer per request
// Notes: ack one cycle after request; unmapped reads zero
`include "pin_mux_consts.svh"

module pin_mux_cfg_regs
    import pin_mux_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // wishbone
    input wire logic i_cyc,
    input wire logic i_stb,
    input wire logic i_we,
    input wire logic [7:0] i_adr,
    input wire logic [3:0] i_sel,
    input wire logic [31:0] i_dat,
    output logic [31:0] o_dat,
    output logic o_ack,
    // register contents and readback
    input wire logic [15:0] i_status,
    output pin_mux_pkg::cfg_t o_mode_sel,
    output pin_mux_pkg::cfg_t o_ext_cfg,
    output pin_mux_pkg::cfg_t o_fdc_cfg,
    output pin_mux_pkg::cfg_t o_clk_cfg
);
    logic req;
    logic wr;
    logic [31:0] rd_nxt;

    assign req = i_cyc & i_stb & ~o_ack;
    // write lands on the edge at which the master sees ack
    assign wr = i_cyc & i_stb & o_ack & i_we & i_sel[0];

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_ack <= 1'b0;
        end else begin
            o_ack <= req;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_mode_sel <= `PM_RST_REG;
            o_ext_cfg <= `PM_RST_REG;
            o_fdc_cfg <= `PM_RST_REG;
            o_clk_cfg <= `PM_RST_REG;
        end else if (wr) begin
            case (i_adr)
                `PM_OFS_MODE_SEL: o_mode_sel <= i_dat[7:0];
                `PM_OFS_EXT_CFG: o_ext_cfg <= i_dat[7:0];
                `PM_OFS_FDC_CFG: o_fdc_cfg <= i_dat[7:0];
                `PM_OFS_CLK_CFG: o_clk_cfg <= i_dat[7:0];
                default: o_clk_cfg <= o_clk_cfg;
            endcase
        end
    end

    always_comb begin
        rd_nxt = 32'h0;
        case (i_adr)
            `PM_OFS_MODE_SEL: rd_nxt[7:0] = o_mode_sel;
            `PM_OFS_EXT_CFG: rd_nxt[7:0] = o_ext_cfg;
            `PM_OFS_FDC_CFG: rd_nxt[7:0] = o_fdc_cfg;
            `PM_OFS_CLK_CFG: rd_nxt[7:0] = o_clk_cfg;
            `PM_OFS_STATUS: rd_nxt[15:0] = i_status;
            default: rd_nxt = 32'h0;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_dat <= 32'h0;
        end else if (req) begin
            o_dat <= rd_nxt;
        end
    end
endmodule

/* File: design/pin_mux_consts.svh */
// Purpose: offsets, field positions, reset values and pin indices
// Assumes: byte addresses on a 32-bit classic wishbone bus
// Notes: config registers are eight bits wide in the low lane, status sixteen
`ifndef PIN_MUX_CONSTS_SVH
`define PIN_MUX_CONSTS_SVH

// register byte offsets
`define PM_OFS_MODE_SEL 8'h00
`define PM_OFS_EXT_CFG 8'h04
`define PM_OFS_FDC_CFG 8'h08
`define PM_OFS_CLK_CFG 8'h0c
`define PM_OFS_STATUS 8'h10

// fields and codes
`define PM_BIT_ALT_EN 0
`define PM_EXT_ONE 2'h1
`define PM_EXT_TWO 2'h2
`define PM_BIT_PULL_DIS 7
`define PM_BIT_CLK48 0
`define PM_RST_REG 8'h00

// native open-drain floppy pins
`define PM_OD_DENSITY 0
`define PM_OD_MOTOR0 1
`define PM_OD_DRIVE_B 2
`define PM_OD_DRIVE_A 3
`define PM_OD_MOTOR1 4
`define PM_OD_DIR 5
`define PM_OD_STEP 6
`define PM_OD_WSTREAM 7
`define PM_OD_WGATE 8
`define PM_OD_SIDE 9

// printer status pins: online, paper, busy, ack_n, err_n
`define PM_ST_ONLINE 0
`define PM_ST_PAPER 1
`define PM_ST_BUSY 2
`define PM_ST_ACK 3
`define PM_ST_ERR 4
`define PM_PRN_IDLE 5'h1c

// printer control pins: strobe, autolf, select-in, init
`define PM_CT_STROBE 0
`define PM_CT_AUTOLF 1
`define PM_CT_SELIN 2
`define PM_CT_INIT 3

// sense order: index, outer track, wprot, rdata, media change
`define PM_SN_INDEX 0
`define PM_SN_TRACK0 1

`endif

/* File: design/pin_mux_pkg.sv */
// Purpose: types shared by the pin multiplexer files
// Assumes: nothing
// Notes: mode codes follow a gray path
package pin_mux_pkg;
    typedef enum logic [1:0] {
        M_PRINTER = 2'h0,
        M_EXT_ONE = 2'h1,
        M_EXT_TWO = 2'h3
    } mode_t;
    typedef logic [7:0] cfg_t;
endpackage

/* File: design/printer_port_floppy_pin_mux.sv */
// Purpose: printer port pins shared with an external floppy interface
// Assumes: all pin inputs synchronous to I_CORE_CLK
// Notes: pin outputs are registered, one cycle behind their sources
`include "pin_mux_consts.svh"

// Function
// - two registers pick printer or floppy pins
// - head direction high outward, low inward
// - side select high side 0, low side 1
// - motor outputs low run drives, open-drain
// - drive select outputs low enable drives
// - active-low step pulse per track move
// - active-low write data, open-drain write gate
// - index and track zero sensed active low
// - write protect sensed active low
// - media change sensed active low
// - config bit 7 disables floppy input pull-ups
// - core clock 24 or 48 MHz, default 24
// - printer inputs online, paper out, busy high
// - printer inputs ack and error active low
// - active-low strobe and auto line feed
// - drive select-in and initialize outputs
// - gate, data, motor1, drive B, side onto status pins
// - density, step, dir onto control pins
// - external index from data bit 0
// - strobe pin floats in floppy modes
// - one-drive serves B, two-drive A and B
// - track0, wprot, rdata, change from bits 1-4
// - two-drive motor0, drive A on bits 6,7
module printer_port_floppy_pin_mux
    import pin_mux_pkg::*;
(
    // clock and reset
    input wire logic I_CORE_CLK,
    input wire logic I_RSTN,
    // wishbone slave
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [7:0] I_WB_ADR,
    input wire logic [3:0] I_WB_SEL,
    input wire logic [31:0] I_WB_DAT,
    output logic [31:0] O_WB_DAT,
    output logic O_WB_ACK,
    // floppy controller core, native levels
    input wire logic I_FDC_DENSITY_SEL0,
    input wire logic I_FDC_MOTOR0_ON_N,
    input wire logic I_FDC_DRIVE_B_PICK_N,
    input wire logic I_FDC_DRIVE_A_PICK_N,
    input wire logic I_FDC_MOTOR1_ON_N,
    input wire logic I_FDC_HEAD_OUTWARD,
    input wire logic I_FDC_STEP_N,
    input wire logic I_FDC_WRITE_STREAM_N,
    input wire logic I_FDC_WRITE_GATE_N,
    input wire logic I_FDC_SIDE0,
    output logic [4:0] O_FDC_SENSE_N,
    // native floppy pins
    output logic [9:0] O_FDD_OD_O,
    output logic [9:0] O_FDD_OD_OE,
    input wire logic [4:0] I_FDD_SENSE_N,
    output logic O_FDD_PULLUP_EN,
    // printer core
    input wire logic I_PRN_STROBE_N,
    input wire logic I_PRN_AUTOLF_N,
    input wire logic I_PRN_SELECT_IN_N,
    input wire logic I_PRN_INIT_N,
    input wire logic [7:0] I_PRN_DATA_O,
    input wire logic I_PRN_DATA_OE,
    output logic [4:0] O_PRN_STATUS,
    output logic [7:0] O_PRN_DATA_I,
    // shared port pins
    input wire logic [4:0] I_STAT_PIN,
    output logic [4:0] O_STAT_PIN,
    output logic [4:0] O_STAT_PIN_OE,
    output logic [3:0] O_CTL_PIN,
    output logic [3:0] O_CTL_PIN_OE,
    input wire logic [7:0] I_PD_PIN,
    output logic [7:0] O_PD_PIN,
    output logic [7:0] O_PD_PIN_OE,
    // clock and mode status
    output logic O_CLK_48M_SEL,
    output pin_mux_pkg::mode_t O_PORT_MODE
);
    cfg_t mode_sel;
    cfg_t ext_cfg;
    cfg_t fdc_cfg;
    cfg_t clk_cfg;
    mode_t mode_r;
    mode_t mode_nxt;
    logic ext_on;
    logic ext_use;
    logic [9:0] fdd_lvl;
    logic [4:0] stat_oe_nxt;
    logic [3:0] ctl_oe_nxt;
    logic [7:0] pd_o_nxt;
    logic [7:0] pd_oe_nxt;
    logic [4:0] sense_nxt;
    logic [4:0] prn_stat_nxt;
    logic [7:0] prn_data_nxt;
    logic [15:0] status;

    // register file
    pin_mux_cfg_regs u_regs (
        .i_clk(I_CORE_CLK),
        .i_rstn(I_RSTN),
        .i_cyc(I_WB_CYC),
        .i_stb(I_WB_STB),
        .i_we(I_WB_WE),
        .i_adr(I_WB_ADR),
        .i_sel(I_WB_SEL),
        .i_dat(I_WB_DAT),
        .o_dat(O_WB_DAT),
        .o_ack(O_WB_ACK),
        .i_status(status),
        .o_mode_sel(mode_sel),
        .o_ext_cfg(ext_cfg),
        .o_fdc_cfg(fdc_cfg),
        .o_clk_cfg(clk_cfg)
    );

    assign status = {I_PD_PIN, sense_nxt, ext_use, mode_r};

    // mode decode from both registers
    always_comb begin
        mode_nxt = M_PRINTER;
        if (mode_sel[`PM_BIT_ALT_EN]) begin
            case (ext_cfg[1:0])
                `PM_EXT_ONE: mode_nxt = M_EXT_ONE;
                `PM_EXT_TWO: mode_nxt = M_EXT_TWO;
                default: mode_nxt = M_PRINTER;
            endcase
        end
    end

    // mode state, printer out of reset
    always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            mode_r <= M_PRINTER;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    assign O_PORT_MODE = mode_r;
    assign ext_on = (mode_r != M_PRINTER);
    assign ext_use = (mode_r == M_EXT_TWO) ||
        ((mode_r == M_EXT_ONE) && !I_FDC_DRIVE_B_PICK_N);

    // native floppy pin levels
    always_comb begin
        fdd_lvl[`PM_OD_DENSITY] = I_FDC_DENSITY_SEL0;
        fdd_lvl[`PM_OD_MOTOR0] = I_FDC_MOTOR0_ON_N;
        fdd_lvl[`PM_OD_DRIVE_B] = I_FDC_DRIVE_B_PICK_N;
        fdd_lvl[`PM_OD_DRIVE_A] = I_FDC_DRIVE_A_PICK_N;
        fdd_lvl[`PM_OD_MOTOR1] = I_FDC_MOTOR1_ON_N;
        fdd_lvl[`PM_OD_DIR] = I_FDC_HEAD_OUTWARD;
        fdd_lvl[`PM_OD_STEP] = I_FDC_STEP_N;
        fdd_lvl[`PM_OD_WSTREAM] = I_FDC_WRITE_STREAM_N;
        fdd_lvl[`PM_OD_WGATE] = I_FDC_WRITE_GATE_N;
        fdd_lvl[`PM_OD_SIDE] = I_FDC_SIDE0;
        // drives served by the port are idle on native pins
        if (ext_on) begin
            fdd_lvl[`PM_OD_DRIVE_B] = 1'b1;
            fdd_lvl[`PM_OD_MOTOR1] = 1'b1;
        end
        if (mode_r == M_EXT_TWO) begin
            fdd_lvl[`PM_OD_DRIVE_A] = 1'b1;
            fdd_lvl[`PM_OD_MOTOR0] = 1'b1;
        end
    end

    // open-drain cells: pull low for a low level
    genvar g;
    generate
        for (g = 0; g < 10; g++) begin : g_od
            always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
                if (!I_RSTN) begin
                    O_FDD_OD_OE[g] <= 1'b0;
                end else begin
                    O_FDD_OD_OE[g] <= ~fdd_lvl[g];
                end
            end
        end
    endgenerate

    assign O_FDD_OD_O = 10'h000;

    // shared pin drive
    always_comb begin
        stat_oe_nxt = 5'h00;
        ctl_oe_nxt[`PM_CT_STROBE] = ~I_PRN_STROBE_N;
        ctl_oe_nxt[`PM_CT_AUTOLF] = ~I_PRN_AUTOLF_N;
        ctl_oe_nxt[`PM_CT_SELIN] = ~I_PRN_SELECT_IN_N;
        ctl_oe_nxt[`PM_CT_INIT] = ~I_PRN_INIT_N;
        pd_o_nxt = I_PRN_DATA_O;
        pd_oe_nxt = {8{I_PRN_DATA_OE}};
        case (mode_r)
            M_PRINTER: begin
                stat_oe_nxt = 5'h00;
            end
            M_EXT_ONE, M_EXT_TWO: begin
                // printer core drivers cut off
                stat_oe_nxt[`PM_ST_ONLINE] = ~I_FDC_WRITE_GATE_N;
                stat_oe_nxt[`PM_ST_PAPER] = ~I_FDC_WRITE_STREAM_N;
                stat_oe_nxt[`PM_ST_BUSY] = ~I_FDC_MOTOR1_ON_N;
                stat_oe_nxt[`PM_ST_ACK] = ~I_FDC_DRIVE_B_PICK_N;
                stat_oe_nxt[`PM_ST_ERR] = ~I_FDC_SIDE0;
                ctl_oe_nxt[`PM_CT_STROBE] = 1'b0;
                ctl_oe_nxt[`PM_CT_AUTOLF] = ~I_FDC_DENSITY_SEL0;
                ctl_oe_nxt[`PM_CT_SELIN] = ~I_FDC_STEP_N;
                ctl_oe_nxt[`PM_CT_INIT] = ~I_FDC_HEAD_OUTWARD;
                pd_o_nxt = 8'h00;
                pd_oe_nxt = 8'h00;
                if (mode_r == M_EXT_TWO) begin
                    pd_oe_nxt[6] = ~I_FDC_MOTOR0_ON_N;
                    pd_oe_nxt[7] = ~I_FDC_DRIVE_A_PICK_N;
                end
            end
            default: begin
                stat_oe_nxt = 5'h00;
            end
        endcase
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_STAT_PIN_OE <= 5'h00;
            O_CTL_PIN_OE <= 4'h0;
            O_PD_PIN <= 8'h00;
            O_PD_PIN_OE <= 8'h00;
        end else begin
            O_STAT_PIN_OE <= stat_oe_nxt;
            O_CTL_PIN_OE <= ctl_oe_nxt;
            O_PD_PIN <= pd_o_nxt;
            O_PD_PIN_OE <= pd_oe_nxt;
        end
    end

    assign O_STAT_PIN = 5'h00;
    assign O_CTL_PIN = 4'h0;

    // floppy sense inputs, native or from port data
    always_comb begin
        sense_nxt = I_FDD_SENSE_N;
        if (ext_use) begin
            sense_nxt = I_PD_PIN[4:0];
        end
    end

    // printer core inputs, idle while pins carry floppy signals
    always_comb begin
        prn_stat_nxt = I_STAT_PIN;
        prn_data_nxt = I_PD_PIN;
        if (ext_on) begin
            prn_stat_nxt = `PM_PRN_IDLE;
            prn_data_nxt = 8'h00;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_FDC_SENSE_N <= 5'h1f;
            O_PRN_STATUS <= `PM_PRN_IDLE;
            O_PRN_DATA_I <= 8'h00;
        end else begin
            O_FDC_SENSE_N <= sense_nxt;
            O_PRN_STATUS <= prn_stat_nxt;
            O_PRN_DATA_I <= prn_data_nxt;
        end
    end

    // pull-ups and clock select
    always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_FDD_PULLUP_EN <= 1'b1;
            O_CLK_48M_SEL <= 1'b0;
        end else begin
            O_FDD_PULLUP_EN <= ~fdc_cfg[`PM_BIT_PULL_DIS];
            O_CLK_48M_SEL <= clk_cfg[`PM_BIT_CLK48];
        end
    end

    // checks
    chk_reset_mode: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_RSTN)
        !$past(I_RSTN) |-> (mode_r == M_PRINTER) && !O_CLK_48M_SEL)
        else $error("not in printer mode after reset");

    chk_mode_decode: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_RSTN)
        ($past(mode_sel[`PM_BIT_ALT_EN]) && $past(ext_cfg[1:0]) == 2'h2)
        |-> mode_r == M_EXT_TWO)
        else $error("two-drive selection not taken");

    chk_strobe_float: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_RSTN)
        ($past(mode_r) != M_PRINTER) |-> !O_CTL_PIN_OE[`PM_CT_STROBE])
        else $error("strobe pin driven in floppy mode");

    chk_wgate_route: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_RSTN)
        ($past(mode_r) != M_PRINTER) |->
        O_STAT_PIN_OE[`PM_ST_ONLINE] == !$past(I_FDC_WRITE_GATE_N))
        else $error("write gate not on online pin");

    chk_step_route: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_RSTN)
        ($past(mode_r) != M_PRINTER) |->
        O_CTL_PIN_OE[`PM_CT_SELIN] == !$past(I_FDC_STEP_N))
        else $error("step not on select-in pin");

    chk_index_merge: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_RSTN)
        ($past(mode_r) == M_EXT_TWO) |->
        O_FDC_SENSE_N[`PM_SN_INDEX] == $past(I_PD_PIN[0]))
        else $error("external index not taken from data bit 0");

    chk_one_drive_pd: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_RSTN)
        ($past(mode_r) == M_EXT_ONE) |-> O_PD_PIN_OE == 8'h00)
        else $error("data pins driven in one-drive mode");

    chk_native_idle: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_RSTN)
        ($past(mode_r) != M_PRINTER) |->
        !O_FDD_OD_OE[`PM_OD_DRIVE_B] && !O_FDD_OD_OE[`PM_OD_MOTOR1])
        else $error("native drive B active in floppy mode");

    chk_dir_polarity: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_RSTN)
        $past(I_FDC_HEAD_OUTWARD) |-> !O_FDD_OD_OE[`PM_OD_DIR])
        else $error("direction pulled low for outward motion");

    chk_prn_status: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_RSTN)
        ($past(I_RSTN) && $past(mode_r) == M_PRINTER) |->
        O_PRN_STATUS == $past(I_STAT_PIN))
        else $error("printer status not passed through");

    chk_pullup_ctl: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_RSTN)
        $rose(fdc_cfg[`PM_BIT_PULL_DIS]) |=> !O_FDD_PULLUP_EN [*2])
        else $error("pull-ups left on after disable");
endmodule

/* File: verification/prn_fdd_far_side.sv */
// Purpose: printer and external drive seen on the shared port pins
// Assumes: every released line is pulled high
// Notes: i_prn_on attaches a printer, i_fdd_on an external drive
module prn_fdd_far_side (
    // attach controls
    input wire logic i_prn_on,
    input wire logic i_fdd_on,
    // far-side levels
    input wire logic [4:0] i_prn_stat,
    input wire logic [4:0] i_drive_sense_n,
    // device pin drivers
    input wire logic [4:0] i_stat_o,
    input wire logic [4:0] i_stat_oe,
    input wire logic [7:0] i_pd_o,
    input wire logic [7:0] i_pd_oe,
    // resolved wires
    output logic [4:0] o_stat_wire,
    output logic [7:0] o_pd_wire
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] far_pd;
    always_comb begin
        // printer status wired-and with device pull-downs
        o_stat_wire = (i_prn_on ? i_prn_stat : 5'h1f)
            & (i_stat_o | ~i_stat_oe);
        // drive sense on bits 0-4, the rest pulled high
        far_pd = i_fdd_on ? {3'h7, i_drive_sense_n} : 8'hff;
        for (int i = 0; i < 8; i++) begin
            o_pd_wire[i] = i_pd_oe[i] ? i_pd_o[i] : far_pd[i];
        end
    end
endmodule

/* File: verification/tb_printer_port_floppy_pin_mux.sv */
// Purpose: self-checking bench for the printer port floppy pin mux
// Assumes: far-side model resolves the shared pins with pull-ups
// Notes: pin outputs settle within three edges of a change
`include "pin_mux_consts.svh"

module tb_printer_port_floppy_pin_mux;
    import pin_mux_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic prn_doe = 1'b0, prn_on = 1'b1, fdd_on = 1'b0, wb_ack;
    logic pull_en, clk48;
    logic [7:0] adr = 8'h00, prn_do = 8'h00, prn_di, pd_o, pd_oe, pd_wire;
    logic [3:0] sel = 4'h0, prn_ctl = 4'hf, ctl_o, ctl_oe;
    logic [31:0] dat = 32'h0, q, wb_q;
    logic [9:0] f = 10'h3ff, od_o, od_oe;
    logic [4:0] nat = 5'h1f, drv = 5'h1f, prn_stat = 5'h1f;
    logic [4:0] sense_n, prn_status, stat_o, stat_oe, stat_wire;
    mode_t mode;
    int n_mismatch = 0, n_compared = 0;
    logic [9:0] pat [2] = '{10'h2a5, 10'h15a};
    wire logic [9:0] fdd_lvl = od_o | ~od_oe;
    wire logic [3:0] ctl_lvl = ctl_o | ~ctl_oe;

    always #2 clk = ~clk;

    printer_port_floppy_pin_mux printer_port_floppy_pin_mux_i (
        .I_CORE_CLK(clk), .I_RSTN(rstn), .I_WB_CYC(cyc), .I_WB_STB(stb),
        .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(dat),
        .O_WB_DAT(wb_q), .O_WB_ACK(wb_ack), .I_FDC_DENSITY_SEL0(f[0]),
        .I_FDC_MOTOR0_ON_N(f[1]), .I_FDC_DRIVE_B_PICK_N(f[2]),
        .I_FDC_DRIVE_A_PICK_N(f[3]), .I_FDC_MOTOR1_ON_N(f[4]),
        .I_FDC_HEAD_OUTWARD(f[5]), .I_FDC_STEP_N(f[6]),
        .I_FDC_WRITE_STREAM_N(f[7]), .I_FDC_WRITE_GATE_N(f[8]),
        .I_FDC_SIDE0(f[9]), .O_FDC_SENSE_N(sense_n), .O_FDD_OD_O(od_o),
        .O_FDD_OD_OE(od_oe), .I_FDD_SENSE_N(nat), .O_FDD_PULLUP_EN(pull_en),
        .I_PRN_STROBE_N(prn_ctl[0]), .I_PRN_AUTOLF_N(prn_ctl[1]),
        .I_PRN_SELECT_IN_N(prn_ctl[2]), .I_PRN_INIT_N(prn_ctl[3]),
        .I_PRN_DATA_O(prn_do), .I_PRN_DATA_OE(prn_doe),
        .O_PRN_STATUS(prn_status), .O_PRN_DATA_I(prn_di),
        .I_STAT_PIN(stat_wire), .O_STAT_PIN(stat_o), .O_STAT_PIN_OE(stat_oe),
        .O_CTL_PIN(ctl_o), .O_CTL_PIN_OE(ctl_oe), .I_PD_PIN(pd_wire),
        .O_PD_PIN(pd_o), .O_PD_PIN_OE(pd_oe), .O_CLK_48M_SEL(clk48),
        .O_PORT_MODE(mode));

    prn_fdd_far_side prn_fdd_far_side_i (
        .i_prn_on(prn_on), .i_fdd_on(fdd_on), .i_prn_stat(prn_stat),
        .i_drive_sense_n(drv), .i_stat_o(stat_o), .i_stat_oe(stat_oe),
        .i_pd_o(pd_o), .i_pd_oe(pd_oe), .o_stat_wire(stat_wire),
        .o_pd_wire(pd_wire));

    task automatic conclude();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, exp, input string m);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s seen %h want %h", $time, m, seen, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a,
            input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 40);
        if (wb_ack !== 1'b1) begin
            n_mismatch++;
            conclude();
        end
        q = wb_q;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic set_pins(input int k);
        @(posedge clk);
        f <= pat[k];
        nat <= 5'h0c ^ {5{k[0]}};
        drv <= 5'h13 ^ {5{k[0]}};
        prn_ctl <= pat[k][3:0];
        prn_do <= pat[k][7:0];
        prn_doe <= 1'b1;
        prn_stat <= pat[k][9:5];
        settle();
    endtask

    task automatic t_reset();
        settle();
        chk(32'(mode), 32'(M_PRINTER), "mode");
        chk(32'(pull_en), 32'h1, "pull-up");
        chk(32'(clk48), 32'h0, "clock");
        for (int a = 0; a < 16; a += 4) begin
            wb(1'b0, 8'(a), 32'h0, 4'h0);
            chk(q, 32'h0, "reset value");
        end
        $display("test reset done");
    endtask

    task automatic t_regs();
        wb(1'b1, `PM_OFS_FDC_CFG, 32'h80, 4'h1);
        wb(1'b1, `PM_OFS_CLK_CFG, 32'h1, 4'h1);
        wb(1'b1, `PM_OFS_FDC_CFG, 32'h0, 4'h2);
        wb(1'b1, 8'h14, 32'hff, 4'h1);
        wb(1'b1, `PM_OFS_STATUS, 32'hff, 4'h1);
        settle();
        chk(32'(pull_en), 32'h0, "pull-up off");
        chk(32'(clk48), 32'h1, "48 MHz");
        wb(1'b0, `PM_OFS_FDC_CFG, 32'h0, 4'h0);
        chk(q, 32'h80, "lane gating");
        wb(1'b0, 8'h14, 32'h0, 4'h0);
        chk(q, 32'h0, "unmapped");
        wb(1'b0, `PM_OFS_STATUS, 32'h0, 4'h0);
        chk(32'(q[1:0]), 32'h0, "status mode");
        wb(1'b1, `PM_OFS_FDC_CFG, 32'h0, 4'h1);
        wb(1'b1, `PM_OFS_CLK_CFG, 32'h0, 4'h1);
        settle();
        chk(32'(pull_en), 32'h1, "pull-up on");
        chk(32'(clk48), 32'h0, "24 MHz");
        $display("test regs done");
    endtask

    task automatic t_printer();
        wb(1'b1, `PM_OFS_EXT_CFG, 32'h2, 4'h1);
        settle();
        chk(32'(mode), 32'(M_PRINTER), "no alt enable");
        for (int k = 0; k < 2; k++) begin
            set_pins(k);
            chk(32'(fdd_lvl[6:5]), 32'(f[6:5]), "dir");
            chk(32'(fdd_lvl[9:7]), 32'(f[9:7]), "hd");
            chk(32'(fdd_lvl[4:0]), 32'(f[4:0]), "drv");
            chk(32'(sense_n), 32'(nat), "sense");
            chk(32'(prn_status), 32'(prn_stat), "st");
            chk(32'(ctl_lvl), 32'(prn_ctl), "ctl");
            chk(32'(pd_wire), 32'(prn_do), "pd out");
            chk(32'(prn_di), 32'(prn_do), "pd in");
        end
        $display("test printer done");
    endtask

    task automatic t_ext(input logic two);
        wb(1'b1, `PM_OFS_EXT_CFG, two ? 32'h2 : 32'h1, 4'h1);
        wb(1'b1, `PM_OFS_MODE_SEL, 32'h1, 4'h1);
        prn_on <= 1'b0;
        fdd_on <= 1'b1;
        settle();
        chk(32'(mode), two ? 32'h3 : 32'h1, "mode");
        for (int k = 0; k < 2; k++) begin
            set_pins(k);
            chk(32'(stat_wire), 32'({f[9], f[2], f[4], f[7], f[8]}),
                "stat");
            chk(32'(ctl_lvl), 32'({f[5], f[6], f[0], 1'b1}),
                "ctl");
            chk(32'(pd_wire[7:5]), two ? 32'({f[3], f[1], 1'b1}) : 32'h7,
                "pd hi");
            chk(32'(sense_n), 32'((two || !f[2]) ? drv : nat),
                "sense");
            chk(32'(fdd_lvl), 32'(f | (two ? 10'h01e : 10'h014)),
                "native");
            chk(32'(prn_status), 32'h1c, "core st");
            chk(32'(prn_di), 32'h0, "core pd");
        end
        wb(1'b1, `PM_OFS_MODE_SEL, 32'h0, 4'h1);
        prn_on <= 1'b1;
        fdd_on <= 1'b0;
        settle();
        chk(32'(mode), 32'(M_PRINTER), "back");
        $display("test external mode done");
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_regs();
        t_printer();
        t_ext(1'b0);
        t_ext(1'b1);
        conclude();
    end
endmodule
